/* verilog/occ_regs.sv */
// module: output channel control registers and per-channel source logic
// ----------------------------------------------------------------
// Behaviour
// - on/off bits 9:0 request each channel
// - on/off bits reset to zero
// - bits 11:10 always one, reset C00
// - selector 0x follows the on/off bit
// - selector 10 follows the input pin
// - selector 11 ANDs bit and pin
// - bank A holds channels 1-6, reset AAA
// - bank B holds channels 7-10, reset 0AA
// - pairing bit joins channel with next
// - lower channel drives all paired outputs
// - pairing only within groups 1-4,5-6,7-10
// - pairing resets zero, unused bits zero
// - diagnosis bits stay per channel
module occ_regs
	import occ_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// register write/read port from the serial frame decoder
	input wire logic wr_en,
	input wire logic [1:0] wr_sel,
	input wire logic [occ_pkg::REG_W-1:0] wr_data,
	input wire logic [1:0] rd_sel,
	output logic [occ_pkg::REG_W-1:0] rd_data,
	// parallel input pins, one per channel
	input wire logic [occ_pkg::CHANNELS-1:0] channel_input_pin,
	// per-channel diagnosis error from the output stages
	input wire logic [occ_pkg::CHANNELS-1:0] diag_err,
	// outputs
	output logic [occ_pkg::CHANNELS-1:0] channel_drive,
	output logic [occ_pkg::CHANNELS-1:0] channel_diag
);
	import occ_pkg::*;

	logic [11:0] channel_on_off;
	logic [11:0] source_select_bank_a;
	logic [11:0] source_select_bank_b;
	logic [11:0] channel_pairing;
	logic [CHANNELS-1:0] own_cmd;
	logic [CHANNELS-1:0] next_drive;
	logic [CHANNELS-2:0] pair_link;
	logic [11:0] next_rd;

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			channel_on_off <= ON_OFF_RESET;
		end else if (clk_en && wr_en && wr_sel == SEL_ON_OFF) begin
			channel_on_off <= (wr_data & ON_OFF_MASK) | ON_OFF_FIXED;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			source_select_bank_a <= BANK_A_RESET;
		end else if (clk_en && wr_en && wr_sel == SEL_BANK_A) begin
			source_select_bank_a <= wr_data & BANK_A_MASK;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			source_select_bank_b <= BANK_B_RESET;
		end else if (clk_en && wr_en && wr_sel == SEL_BANK_B) begin
			source_select_bank_b <= wr_data & BANK_B_MASK;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			channel_pairing <= PAIRING_RESET;
		end else if (clk_en && wr_en && wr_sel == SEL_PAIRING) begin
			channel_pairing <= wr_data & PAIRING_MASK;
		end
	end

	// ----------------------------------------------------------------
	// read-back
	// ----------------------------------------------------------------
	always_comb begin
		unique case (rd_sel)
			SEL_ON_OFF: next_rd = channel_on_off;
			SEL_BANK_A: next_rd = source_select_bank_a;
			SEL_BANK_B: next_rd = source_select_bank_b;
			SEL_PAIRING: next_rd = channel_pairing;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_data <= ON_OFF_RESET;
		end else if (clk_en) begin
			rd_data <= next_rd;
		end
	end

	// ----------------------------------------------------------------
	// per-channel source selection
	// ----------------------------------------------------------------
	logic [2*CHANNELS-1:0] sel_all;
	assign sel_all = {source_select_bank_b[7:0], source_select_bank_a};

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_src
			logic [1:0] sel;
			assign sel = sel_all[2*g +: 2];
			always_comb begin
				if (!sel[1]) begin
					own_cmd[g] = channel_on_off[g];
				end else if (sel == SRC_PIN) begin
					own_cmd[g] = channel_input_pin[g];
				end else begin
					own_cmd[g] = channel_on_off[g] & channel_input_pin[g];
				end
			end
		end
	endgenerate

	// pairing links between neighbouring channels; no link crosses group borders
	assign pair_link = {channel_pairing[PAIR_9_10], channel_pairing[PAIR_8_9],
		channel_pairing[PAIR_7_8], 1'b0, channel_pairing[PAIR_5_6], 1'b0,
		channel_pairing[PAIR_3_4], channel_pairing[PAIR_2_3],
		channel_pairing[PAIR_1_2]};

	// a chain of set links hands the lowest channel's command upwards
	always_comb begin
		next_drive[0] = own_cmd[0];
		for (int i = 1; i < CHANNELS; i++) begin
			next_drive[i] = pair_link[i-1] ? next_drive[i-1] : own_cmd[i];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			channel_drive <= '0;
		end else if (clk_en) begin
			channel_drive <= next_drive;
		end
	end

	// diagnosis is reported per channel, never merged over a pair
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			channel_diag <= '0;
		end else if (clk_en) begin
			channel_diag <= diag_err;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_fixed_top;
		@(posedge clock) disable iff (rst) channel_on_off[11:10] == 2'h3;
	endproperty
	a_fixed_top: assert property (p_fixed_top) else $error("on/off top bits not one");

	property p_serial;
		@(posedge clock) disable iff (rst)
		clk_en && !source_select_bank_a[1] && !channel_pairing[PAIR_1_2] |=>
		channel_drive[0] == $past(channel_on_off[0]);
	endproperty
	a_serial: assert property (p_serial) else $error("serial channel 1 wrong");

	property p_pin;
		@(posedge clock) disable iff (rst)
		clk_en && source_select_bank_a[1:0] == SRC_PIN |=>
		channel_drive[0] == $past(channel_input_pin[0]);
	endproperty
	a_pin: assert property (p_pin) else $error("pin channel 1 wrong");

	property p_and;
		@(posedge clock) disable iff (rst)
		clk_en && source_select_bank_b[7:6] == SRC_AND && !channel_pairing[PAIR_9_10] |=>
		channel_drive[9] == ($past(channel_on_off[9]) & $past(channel_input_pin[9]));
	endproperty
	a_and: assert property (p_and) else $error("and mode channel 10 wrong");

	property p_bank_b_top;
		@(posedge clock) disable iff (rst) source_select_bank_b[11:8] == 4'h0;
	endproperty
	a_bank_b_top: assert property (p_bank_b_top) else $error("bank b top not zero");

	property p_pair_unused;
		@(posedge clock) disable iff (rst)
		channel_pairing[11:8] == 4'h0 && channel_pairing[3] == 1'b0;
	endproperty
	a_pair_unused: assert property (p_pair_unused) else $error("pairing unused bits set");

	property p_paired;
		@(posedge clock) disable iff (rst)
		clk_en && channel_pairing[PAIR_1_2] |=> channel_drive[1] == channel_drive[0];
	endproperty
	a_paired: assert property (p_paired) else $error("paired channels differ");

	property p_group_border;
		@(posedge clock) disable iff (rst)
		clk_en |=> channel_drive[4] == $past(own_cmd[4]);
	endproperty
	a_group_border: assert property (p_group_border) else $error("pairing crossed group");

	property p_diag;
		@(posedge clock) disable iff (rst)
		clk_en |=> channel_diag == $past(diag_err);
	endproperty
	a_diag: assert property (p_diag) else $error("diagnosis merged or lost");

	property p_reset_on_off;
		@(posedge clock) $fell(rst) |-> channel_on_off == ON_OFF_RESET;
	endproperty
	a_reset_on_off: assert property (p_reset_on_off) else $error("on/off reset wrong");

	property p_reset_a;
		@(posedge clock) $fell(rst) |-> source_select_bank_a == BANK_A_RESET;
	endproperty
	a_reset_a: assert property (p_reset_a) else $error("bank a reset wrong");

	property p_reset_b;
		@(posedge clock) $fell(rst) |-> source_select_bank_b == BANK_B_RESET;
	endproperty
	a_reset_b: assert property (p_reset_b) else $error("bank b reset wrong");

	property p_reset_pairing;
		@(posedge clock) $fell(rst) |-> channel_pairing == PAIRING_RESET;
	endproperty
	a_reset_pairing: assert property (p_reset_pairing) else $error("pair reset wrong");

	property p_reset_drive;
		@(posedge clock) $fell(rst) |-> channel_drive == 10'h000;
	endproperty
	a_reset_drive: assert property (p_reset_drive) else $error("channel on after reset");

	// ----------------------------------------------------------------
	// register write, read-back, freeze, source and pairing checks
	// ----------------------------------------------------------------
	// a write only lands on an enabled edge
	sequence s_write(logic [1:0] code);
		clk_en && wr_en && wr_sel == code;
	endsequence

	sequence s_serial_ch1;
		clk_en && !source_select_bank_a[1];
	endsequence

	property p_on_off_write;
		@(posedge clock) disable iff (rst)
		s_write(SEL_ON_OFF) |=> channel_on_off[9:0] == $past(wr_data[9:0]);
	endproperty
	a_on_off_write: assert property (p_on_off_write) else $error("on/off write lost");

	// serial channel 1 shows the written bit two edges after the write
	property p_write_to_drive;
		@(posedge clock) disable iff (rst)
		s_write(SEL_ON_OFF) ##1 s_serial_ch1 |=> channel_drive[0] == $past(wr_data[0], 2);
	endproperty
	a_write_to_drive: assert property (p_write_to_drive) else $error("late drive");

	property p_bank_a_write;
		@(posedge clock) disable iff (rst)
		s_write(SEL_BANK_A) |=> source_select_bank_a == $past(wr_data);
	endproperty
	a_bank_a_write: assert property (p_bank_a_write) else $error("bank a write lost");

	property p_bank_b_write;
		@(posedge clock) disable iff (rst)
		s_write(SEL_BANK_B) |=> source_select_bank_b[7:0] == $past(wr_data[7:0]);
	endproperty
	a_bank_b_write: assert property (p_bank_b_write) else $error("bank b write lost");

	property p_pairing_write;
		@(posedge clock) disable iff (rst)
		s_write(SEL_PAIRING) |=> channel_pairing[7:4] == $past(wr_data[7:4]) &&
		channel_pairing[2:0] == $past(wr_data[2:0]);
	endproperty
	a_pairing_write: assert property (p_pairing_write) else $error("pair write lost");

	// a low enable freezes every register and output
	property p_freeze;
		@(posedge clock) disable iff (rst)
		!clk_en |=> $stable(channel_on_off) && $stable(channel_pairing) && $stable(channel_drive)
		&& $stable(rd_data) && $stable(channel_diag);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	property p_pin_ch7;
		@(posedge clock) disable iff (rst)
		clk_en && source_select_bank_b[1:0] == SRC_PIN |=>
		channel_drive[6] == $past(channel_input_pin[6]);
	endproperty
	a_pin_ch7: assert property (p_pin_ch7) else $error("pin channel 7 wrong");

	// a full chain 7-10 copies channel 7 whatever the upper channels select
	property p_chain_7_10;
		@(posedge clock) disable iff (rst)
		clk_en && channel_pairing[PAIR_7_8] && channel_pairing[PAIR_8_9] &&
		channel_pairing[PAIR_9_10] |=> channel_drive[9:7] == {3{channel_drive[6]}};
	endproperty
	a_chain_7_10: assert property (p_chain_7_10) else $error("chain 7-10 split");

	property p_pair_5_6;
		@(posedge clock) disable iff (rst)
		clk_en && channel_pairing[PAIR_5_6] |=> channel_drive[5] == channel_drive[4];
	endproperty
	a_pair_5_6: assert property (p_pair_5_6) else $error("paired 5-6 differ");

	property p_group_border_b;
		@(posedge clock) disable iff (rst)
		clk_en |=> channel_drive[6] == $past(own_cmd[6]);
	endproperty
	a_group_border_b: assert property (p_group_border_b) else $error("group 7 joined");

	property p_read_on_off;
		@(posedge clock) disable iff (rst)
		clk_en && rd_sel == SEL_ON_OFF |=> rd_data == $past(channel_on_off);
	endproperty
	a_read_on_off: assert property (p_read_on_off) else $error("on/off read wrong");

	property p_read_pairing;
		@(posedge clock) disable iff (rst)
		clk_en && rd_sel == SEL_PAIRING |=> rd_data == $past(channel_pairing);
	endproperty
	a_read_pairing: assert property (p_read_pairing) else $error("pair read wrong");
endmodule : occ_regs

/* common/occ_pkg.sv */
// package: register map, reset values and source-select encodings of the channel control bank
package occ_pkg;
	localparam int CHANNELS = 10;
	localparam int REG_W = 12;
	// register selector codes on the write/read port
	localparam logic [1:0] SEL_ON_OFF = 2'h0;
	localparam logic [1:0] SEL_BANK_A = 2'h1;
	localparam logic [1:0] SEL_BANK_B = 2'h2;
	localparam logic [1:0] SEL_PAIRING = 2'h3;
	// reset values
	localparam logic [11:0] ON_OFF_RESET = 12'hC00;
	localparam logic [11:0] BANK_A_RESET = 12'hAAA;
	localparam logic [11:0] BANK_B_RESET = 12'h0AA;
	localparam logic [11:0] PAIRING_RESET = 12'h000;
	// fixed and writable fields
	localparam logic [11:0] ON_OFF_FIXED = 12'hC00;
	localparam logic [11:0] ON_OFF_MASK = 12'h3FF;
	localparam logic [11:0] BANK_A_MASK = 12'hFFF;
	localparam logic [11:0] BANK_B_MASK = 12'h0FF;
	localparam logic [11:0] PAIRING_MASK = 12'h0F7;
	// pairing bit positions: bits 0-2 and 4 join channel k with k+1, bits 5-7 join channel k+1 with k+2 (0-based channels)
	localparam int PAIR_1_2 = 0;
	localparam int PAIR_2_3 = 1;
	localparam int PAIR_3_4 = 2;
	localparam int PAIR_5_6 = 4;
	localparam int PAIR_7_8 = 5;
	localparam int PAIR_8_9 = 6;
	localparam int PAIR_9_10 = 7;
	// source-select encodings
	localparam logic [1:0] SRC_PIN = 2'h2;
	localparam logic [1:0] SRC_AND = 2'h3;
endpackage : occ_pkg

/* test/occ_host.sv */
// host model: drives the parallel input pins and merges faults of paralleled loads
module occ_host (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// pin command and fault view
	input wire logic [occ_pkg::CHANNELS-1:0] pin_cmd,
	input wire logic [9:0] pair_mask,
	input wire logic [9:0] channel_diag,
	output logic [9:0] channel_input_pin,
	output logic load_fault
);
	timeunit 1ns;
	timeprecision 1ns;
	import occ_pkg::*;
	// pins move just after the edge, as a timer output of the host would
	always @(posedge clock or posedge rst) begin
		if (rst)
			channel_input_pin <= 10'h000;
		else
			channel_input_pin <= #5 pin_cmd;
	end
	// one channel of a pair may report alone, so the whole load is judged
	assign load_fault = |(channel_diag & pair_mask);
endmodule : occ_host

/* test/occ_regs_tb.sv */
// testbench: register bank reset, access, source modes and pairing
module occ_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import occ_pkg::*;
	logic clock = 0, rst = 1, clk_en = 1, wr_en = 0, load_fault;
	logic [1:0] wr_sel = 0, rd_sel = 0;
	logic [11:0] wr_data = 0, rd_data, a, o, p, e;
	logic [9:0] pin_cmd = 0, pins, diag_err = 0, pair_mask = 0, drive, diag;
	int errors = 0, num_checks = 0;
	// bank A, on/off, pins, expected drive
	logic [47:0] rows [4] = '{48'h000015FFF3D5, 48'h55502A00002A,
		48'hAAA3FF155155, 48'hFFF0FF3F03F0};
	always #50 clock = ~clock;
	occ_regs u_dut (.clock(clock), .rst(rst), .clk_en(clk_en), .wr_en(wr_en),
		.wr_sel(wr_sel), .wr_data(wr_data), .rd_sel(rd_sel), .rd_data(rd_data),
		.channel_input_pin(pins), .diag_err(diag_err), .channel_drive(drive),
		.channel_diag(diag));
	occ_host u_host (.clock(clock), .rst(rst), .pin_cmd(pin_cmd),
		.pair_mask(pair_mask), .channel_diag(diag), .channel_input_pin(pins),
		.load_fault(load_fault));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [11:0] s, input logic [11:0] x);
		num_checks++;
		if (s !== x) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, x);
		end
	endtask : chk
	task automatic wr(input logic [1:0] s, input logic [11:0] d);
		@(posedge clock);
		#5 wr_en = 1;
		wr_sel = s;
		wr_data = d;
		@(posedge clock);
		#5 wr_en = 0;
	endtask : wr
	task automatic rd(input logic [1:0] s, input logic [11:0] x);
		@(posedge clock);
		#5 rd_sel = s;
		repeat (2) @(posedge clock);
		#5 chk(rd_data, x);
	endtask : rd
	// three edges cover pin register, source logic and output register
	task automatic pv(input logic [11:0] v, input logic [11:0] x);
		wr(SEL_ON_OFF, v);
		repeat (3) @(posedge clock);
		#5 chk({2'h0, drive}, x);
	endtask : pv
	task automatic stop_test;
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		#100000 errors++;
		stop_test;
	end
	initial begin
		repeat (2) @(posedge clock);
		#5 chk({2'h0, drive}, 12'h000);
		rst = 0;
		rd(SEL_ON_OFF, 12'hC00);
		rd(SEL_BANK_A, 12'hAAA);
		rd(SEL_BANK_B, 12'h0AA);
		rd(SEL_PAIRING, 12'h000);
		foreach (rows[i]) begin
			{a, o, p, e} = rows[i];
			wr(SEL_BANK_A, a);
			pin_cmd = p[9:0];
			pv(o, e);
			rd(SEL_ON_OFF, 12'hC00 | o);
		end
		wr(SEL_BANK_B, 12'hFFF);
		rd(SEL_BANK_B, 12'h0FF);
		wr(SEL_BANK_B, 12'h000);
		wr(SEL_BANK_A, 12'h000);
		wr(SEL_PAIRING, 12'h001);
		pv(12'h001, 12'h003);
		wr(SEL_PAIRING, 12'hFFF);
		rd(SEL_PAIRING, 12'h0F7);
		pv(12'h001, 12'h00F);
		pv(12'h3EE, 12'h3C0);
		pv(12'h011, 12'h03F);
		// low clock enable: neither the write nor the new fault levels may land
		clk_en = 0;
		wr(SEL_ON_OFF, 12'h000);
		diag_err = 10'h3FF;
		repeat (2) @(posedge clock);
		#5 chk({2'h0, drive}, 12'h03F);
		chk({2'h0, diag}, 12'h000);
		clk_en = 1;
		rd(SEL_ON_OFF, 12'hC11);
		// paired channels set to pin mode must still follow their lowest channel
		wr(SEL_BANK_A, 12'hAA8);
		pin_cmd = 10'h3FE;
		pv(12'h000, 12'h030);
		diag_err = 10'h002;
		pair_mask = 10'h003;
		repeat (2) @(posedge clock);
		#5 chk({2'h0, diag}, 12'h002);
		chk({11'h0, load_fault}, 12'h001);
		// reset in mid-run: defaults return and every channel follows its pin again
		@(posedge clock);
		#5 rst = 1;
		repeat (2) @(posedge clock);
		#5 chk({2'h0, drive}, 12'h000);
		rst = 0;
		rd(SEL_BANK_B, 12'h0AA);
		rd(SEL_PAIRING, 12'h000);
		chk({2'h0, drive}, 12'h3FE);
		rd(SEL_ON_OFF, 12'hC00);
		stop_test;
	end
endmodule : occ_regs_tb
